// ### asev_pkg.sv
`default_nettype none
package asev_pkg;
  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [4:0] REG_MASK = 5'h00;
  localparam logic [4:0] REG_CAUSE = 5'h04;
  localparam logic [4:0] REG_OPMODE = 5'h08;
  localparam logic [4:0] REG_ENV2 = 5'h0C;
  localparam logic [4:0] REG_ENV5 = 5'h10;
  localparam logic [4:0] REG_CMD = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  localparam logic [4:0] REG_FEED = 5'h1C;

  // ==========================================================
  // Field positions
  localparam int EV_LO = 4;
  localparam int EV_HI = 12;
  localparam int MSY_LO = 18;
  localparam int MAX_LO = 20;
  localparam int SYO_LO = 16;
  localparam int SYI_LO = 20;
  localparam int STOP_TRIGGER_MODE_SEL_BIT = 28;
  localparam int WATCH_X_BIT = 0;
  localparam int WATCH_Y_BIT = 1;

  // ==========================================================
  // Codes and reset values
  localparam logic [1:0] MSY_NOW = 2'h0;
  localparam logic [1:0] MSY_SYNC = 2'h2;
  localparam logic [1:0] MSY_STOP = 2'h3;
  localparam logic [1:0] SYI_X = 2'h0;
  localparam logic [1:0] SYI_Y = 2'h1;
  localparam logic [3:0] SYO_CMP_FIRST = 4'h1;
  localparam logic [3:0] SYO_CMP_LAST = 4'h5;
  localparam logic [3:0] SYO_EV_FIRST = 4'h8;
  localparam logic [3:0] SYO_ACC_DONE = 4'h9;
  localparam logic [3:0] SYO_EV_LAST = 4'hB;
  localparam logic [3:0] CND_STOPPED = 4'h0;
  localparam logic [3:0] CND_WAIT_SYNC = 4'h3;
  localparam logic [3:0] CND_WAIT_STOP = 4'h4;
  localparam logic [3:0] CND_RUNNING = 4'h8;
  localparam logic [15:0] CMD_FH_CONST = 16'h0351;
  localparam logic [31:0] MODE_CIRC = 32'h0000_0064;
  localparam logic [31:0] MODE_LINEAR = 32'h0000_0061;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WSTOP = 4'b0010,
    ST_WSYNC = 4'b0100,
    ST_RUN = 4'b1000
  } asev_state_e;
endpackage
`default_nettype wire

// ### asev_axis.sv
`timescale 1ns/1ps
`default_nettype none
module asev_axis
  import asev_pkg::*;
#(
  parameter bit AXIS_IS_Y = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ev_accel_start_in,
  input wire logic ev_accel_done_in,
  input wire logic ev_decel_start_in,
  input wire logic ev_decel_done_in,
  input wire logic [4:0] ev_cmp_hit_in,
  input wire logic op_done_in,
  input wire logic other_running_in,
  input wire logic other_irq_pending_in,
  input wire logic sync_x_in,
  input wire logic sync_y_in,
  output logic op_start_out,
  output logic [31:0] op_mode_out,
  output logic [31:0] op_feed_out,
  output logic op_interp_out,
  output logic running_out,
  output logic sync_out,
  output logic sync_mon_out,
  output logic irq_pending_out,
  output logic irq_n_out
);
  // ==========================================================
  // Registers
  asev_state_e state_q, state_d;
  logic [15:0] mask_q;
  logic [15:0] cause_q;
  logic [31:0] opmode_q;
  logic [31:0] feed_q;
  logic [31:0] env2_q;
  logic [31:0] env5_q;
  logic pending_q;
  logic armed_self_q;
  logic other_prev_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] cur_mode_q;
  logic [31:0] cur_feed_q;
  logic start_q;
  logic sync_q;
  logic irq_n_q;
  logic irq_pend_q;
  logic interp_q;

  // ==========================================================
  // Avalon slave decode: one wait state, effect on the accept edge
  wire req = avs_read_in | avs_write_in;
  wire accept = req & ~wait_q;
  wire wr_acc = accept & avs_write_in;
  wire rd_acc = accept & avs_read_in;
  wire [31:0] bmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                       {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  wire sel_mask = (avs_address_in == REG_MASK);
  wire sel_cause = (avs_address_in == REG_CAUSE);
  wire sel_opmode = (avs_address_in == REG_OPMODE);
  wire sel_env2 = (avs_address_in == REG_ENV2);
  wire sel_env5 = (avs_address_in == REG_ENV5);
  wire sel_cmd = (avs_address_in == REG_CMD);
  wire sel_status = (avs_address_in == REG_STATUS);
  wire sel_feed = (avs_address_in == REG_FEED);
  wire cmd_fh = wr_acc & sel_cmd & (avs_writedata_in[15:0] == CMD_FH_CONST);
  wire cause_clr = rd_acc & sel_cause;

  // ==========================================================
  // Field views
  wire [1:0] msy = opmode_q[MSY_LO+1:MSY_LO];
  wire [1:0] watch = opmode_q[MAX_LO+1:MAX_LO];
  wire enhanced = env2_q[STOP_TRIGGER_MODE_SEL_BIT];
  wire [3:0] syo = env5_q[SYO_LO+3:SYO_LO];
  wire [1:0] syi = env5_q[SYI_LO+1:SYI_LO];
  wire watch_self = AXIS_IS_Y ? watch[WATCH_Y_BIT] : watch[WATCH_X_BIT];
  wire watch_other = AXIS_IS_Y ? watch[WATCH_X_BIT] : watch[WATCH_Y_BIT];
  wire other_fall = other_prev_q & ~other_running_in;
  wire is_run = (state_q == ST_RUN);

  // ==========================================================
  // Events, sync timing select and sync source
  wire [15:0] ev_vec = {3'b000, ev_cmp_hit_in, ev_decel_done_in, ev_decel_start_in,
                        ev_accel_done_in, ev_accel_start_in, 4'h0};
  wire syo_cmp = (syo >= SYO_CMP_FIRST) && (syo <= SYO_CMP_LAST);
  wire syo_ev = (syo >= SYO_EV_FIRST) && (syo <= SYO_EV_LAST);
  wire [3:0] syo_idx_cmp = syo + 4'd7;
  wire [3:0] syo_idx_ev = syo - 4'd4;
  wire sync_fire = syo_cmp ? ev_vec[syo_idx_cmp] : (syo_ev ? ev_vec[syo_idx_ev] : 1'b0);
  wire sync_src = (syi == SYI_Y) ? sync_y_in : ((syi == SYI_X) ? sync_x_in : 1'b0);

  // Legacy mode blocks an axis naming itself: it is already stopped
  wire stop_blocked = ~enhanced & watch_self;
  wire other_ok = ~watch_other | ~other_running_in;
  wire stop_seen = (watch_other & other_fall) | armed_self_q;
  wire stop_trig = ~stop_blocked & (watch != 2'b00) & other_ok & stop_seen;

  // Next operation launch when a start is accepted or the queue drains
  wire launch_idle = cmd_fh & (state_q == ST_IDLE);
  wire launch_q = is_run & op_done_in & pending_q;
  wire launch = launch_idle | launch_q;
  wire go_now = (state_q == ST_WSTOP & stop_trig) | (state_q == ST_WSYNC & sync_src);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (launch_idle) begin
          if (msy == MSY_STOP) state_d = ST_WSTOP;
          else if (msy == MSY_SYNC) state_d = ST_WSYNC;
          else state_d = ST_RUN;
        end
      end
      ST_WSTOP: begin
        if (stop_trig) state_d = ST_RUN;
      end
      ST_WSYNC: begin
        if (sync_src) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (launch_q) begin
          if (msy == MSY_STOP) state_d = ST_WSTOP;
          else if (msy == MSY_SYNC) state_d = ST_WSYNC;
          else state_d = ST_RUN;
        end else if (op_done_in) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  wire [3:0] cnd = (state_q == ST_WSTOP) ? CND_WAIT_STOP :
                   (state_q == ST_WSYNC) ? CND_WAIT_SYNC :
                   (state_q == ST_RUN) ? CND_RUNNING : CND_STOPPED;
  wire direct_start = launch & (msy == MSY_NOW);
  wire start_d = direct_start | go_now;

  // ==========================================================
  // Cause flags: set wins over the read clear
  logic [15:0] cause_d;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_cause
      if (gi >= EV_LO && gi <= EV_HI) begin : g_live
        wire set_b = ev_vec[gi] & mask_q[gi];
        assign cause_d[gi] = set_b | (cause_q[gi] & ~cause_clr);
      end else begin : g_zero
        assign cause_d[gi] = 1'b0;
      end
    end
  endgenerate

  wire own_pend = |cause_d;
  wire [31:0] status_word = {26'h0, other_running_in, is_run, cnd};
  wire [31:0] rd_mux = sel_cause ? {16'h0, cause_q} :
                       sel_opmode ? opmode_q :
                       sel_env2 ? env2_q :
                       sel_env5 ? env5_q :
                       sel_status ? status_word :
                       sel_feed ? feed_q : RST_WORD;

  // ==========================================================
  // Bus and configuration registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= RST_WORD;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) rdata_q <= avs_read_in ? rd_mux : RST_WORD;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mask_q <= 16'h0000;
      opmode_q <= RST_WORD;
      feed_q <= RST_WORD;
      env2_q <= RST_WORD;
      env5_q <= RST_WORD;
    end else begin
      if (wr_acc & sel_mask) mask_q <= (mask_q & ~bmask[15:0]) | (avs_writedata_in[15:0] & bmask[15:0]);
      if (wr_acc & sel_opmode) opmode_q <= (opmode_q & ~bmask) | (avs_writedata_in & bmask);
      if (wr_acc & sel_feed) feed_q <= (feed_q & ~bmask) | (avs_writedata_in & bmask);
      if (wr_acc & sel_env2) env2_q <= (env2_q & ~bmask) | (avs_writedata_in & bmask);
      if (wr_acc & sel_env5) env5_q <= (env5_q & ~bmask) | (avs_writedata_in & bmask);
    end
  end

  // ==========================================================
  // Sequencing state
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      pending_q <= 1'b0;
      armed_self_q <= 1'b0;
      other_prev_q <= 1'b0;
      cur_mode_q <= RST_WORD;
      cur_feed_q <= RST_WORD;
      interp_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      other_prev_q <= other_running_in;
      start_q <= start_d;
      // A start while busy queues the pre-register contents
      if (cmd_fh & (state_q != ST_IDLE)) pending_q <= 1'b1;
      else if (launch_q) pending_q <= 1'b0;
      if (launch) begin
        cur_mode_q <= opmode_q;
        cur_feed_q <= feed_q;
        interp_q <= (opmode_q == MODE_CIRC) | (opmode_q == MODE_LINEAR);
      end
      // Own finish counts as the awaited stop only in enhanced mode
      if (launch_q & (msy == MSY_STOP)) armed_self_q <= enhanced & watch_self;
      else if (state_q != ST_WSTOP) armed_self_q <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cause_q <= 16'h0000;
      sync_q <= 1'b0;
      irq_n_q <= 1'b1;
      irq_pend_q <= 1'b0;
    end else begin
      cause_q <= cause_d;
      sync_q <= sync_fire;
      irq_pend_q <= own_pend;
      irq_n_q <= ~(own_pend | other_irq_pending_in);
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign op_start_out = start_q;
  assign op_mode_out = cur_mode_q;
  assign op_feed_out = cur_feed_q;
  assign op_interp_out = interp_q;
  // One-hot run bit, so the pin is a plain flop output
  assign running_out = state_q[3];
  assign sync_out = sync_q;
  assign sync_mon_out = sync_q;
  assign irq_pending_out = irq_pend_q;
  assign irq_n_out = irq_n_q;

  // ==========================================================
  // Checks
  property p_mask_gate;
    @(posedge clock_in) disable iff (rst_in)
    (ev_accel_start_in & ~mask_q[4]) & ~cause_q[4] |=> ~cause_q[4];
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked accel start latched");

  property p_cmp_latch;
    @(posedge clock_in) disable iff (rst_in)
    ev_cmp_hit_in[2] & mask_q[10] |=> cause_q[10] ##1 ~irq_n_out;
  endproperty
  a_cmp_latch: assert property (p_cmp_latch) else $error("comparator cause missing");

  property p_cause_hold;
    @(posedge clock_in) disable iff (rst_in)
    cause_q[5] & ~cause_clr |=> cause_q[5];
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause lost without read");

  property p_cmp_cause;
    @(posedge clock_in) disable iff (rst_in)
    $rose(cause_q[12]) |-> $past(ev_cmp_hit_in[4] & mask_q[12]);
  endproperty
  a_cmp_cause: assert property (p_cmp_cause) else $error("cause 12 without event");

  property p_stop_start;
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_WSTOP && stop_trig |=> is_run && op_start_out;
  endproperty
  a_stop_start: assert property (p_stop_start) else $error("stop trigger did not start");

  property p_legacy_self;
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_WSTOP && ~enhanced && watch_self |=> state_q == ST_WSTOP;
  endproperty
  a_legacy_self: assert property (p_legacy_self) else $error("legacy self watch started");

  property p_queue_run;
    @(posedge clock_in) disable iff (rst_in)
    is_run && op_done_in && pending_q && msy == MSY_NOW |=> is_run && op_start_out;
  endproperty
  a_queue_run: assert property (p_queue_run) else $error("queued op not started");

  property p_sync_wait;
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_WSYNC && ~sync_src |=> state_q == ST_WSYNC;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("left sync wait early");

  property p_acc_sync;
    @(posedge clock_in) disable iff (rst_in)
    syo == SYO_ACC_DONE && ev_accel_done_in |=> sync_out && sync_mon_out;
  endproperty
  a_acc_sync: assert property (p_acc_sync) else $error("no sync at accel done");

  property p_cnd_codes;
    @(posedge clock_in) disable iff (rst_in)
    (rd_acc && sel_status && $past(state_q) == ST_WSTOP |-> avs_readdata_out[3:0] == CND_WAIT_STOP) and
    (rd_acc && sel_status && $past(state_q) == ST_WSYNC |-> avs_readdata_out[3:0] == CND_WAIT_SYNC);
  endproperty
  a_cnd_codes: assert property (p_cnd_codes) else $error("wrong wait status code");

  property p_clear;
    @(posedge clock_in) disable iff (rst_in)
    cause_clr && ev_vec == 16'h0000 |=> cause_q == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("cause read did not clear");

  property p_irq_all;
    @(posedge clock_in) disable iff (rst_in)
    other_irq_pending_in |=> ~irq_n_out;
  endproperty
  a_irq_all: assert property (p_irq_all) else $error("irq released while other pending");

  property p_cmd_start;
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_IDLE && cmd_fh && msy == MSY_NOW |=> is_run && op_start_out;
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("start command did not start");

  property p_both_wait;
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_WSTOP && watch_other && other_running_in |=> state_q == ST_WSTOP;
  endproperty
  a_both_wait: assert property (p_both_wait) else $error("started while watched axis runs");

  property p_self_chain;
    @(posedge clock_in) disable iff (rst_in)
    state_q == ST_WSTOP && armed_self_q && enhanced && watch_self && other_ok |=> is_run && op_start_out;
  endproperty
  a_self_chain: assert property (p_self_chain) else $error("own finish did not start queued op");

  c_stop_start: cover property (@(posedge clock_in) disable iff (rst_in) state_q == ST_WSTOP ##1 is_run);
  c_sync_start: cover property (@(posedge clock_in) disable iff (rst_in) state_q == ST_WSYNC ##1 is_run);
  c_chain: cover property (@(posedge clock_in) disable iff (rst_in) launch_q);
  c_both: cover property (@(posedge clock_in) disable iff (rst_in) state_q == ST_WSTOP && watch == 2'b11 ##1 is_run);
  c_clear: cover property (@(posedge clock_in) disable iff (rst_in) cause_clr && cause_q != 16'h0000);
endmodule
`default_nettype wire

// ### asev_far_axis.sv
`timescale 1ns/1ps
`default_nettype none
module asev_far_axis #(
  parameter int RUN_CYC = 12,
  parameter int ACC_CYC = 4
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic pend_in,
  output logic running_out,
  output logic sync_out,
  output logic pend_out
);
  // ==========
  // Far axis: fixed-length move, sync pulse at end of acceleration
  int cnt_q;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 0;
      running_out <= 1'b0;
      sync_out <= 1'b0;
      pend_out <= 1'b0;
    end else begin
      pend_out <= pend_in;
      sync_out <= running_out && (cnt_q == ACC_CYC);
      if (go_in && !running_out) begin
        running_out <= 1'b1;
        cnt_q <= 0;
      end else if (running_out) begin
        cnt_q <= cnt_q + 1;
        // A go request while moving is ignored, as a busy axis would
        if (cnt_q == RUN_CYC - 1) begin
          running_out <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test_axis_start_sync_and_event_causes.sv
`timescale 1ns/1ps
`default_nettype none
module test_axis_start_sync_and_event_causes
  import asev_pkg::*;
;
  logic clk, rst, rd_en, wr_en, wreq, done, go, pend;
  logic [4:0] addr;
  logic [31:0] wdat, rdat, v, mode, feed;
  logic [8:0] ev;
  logic start, run, sync, mon, ipend, irq_n, interp, o_run, o_sync, o_pend;
  int num_errors, checks_done, starts, syncs;

  asev_axis #(.AXIS_IS_Y(1'b0)) u_dut (
    .clock_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .ev_accel_start_in(ev[0]), .ev_accel_done_in(ev[1]), .ev_decel_start_in(ev[2]),
    .ev_decel_done_in(ev[3]), .ev_cmp_hit_in(ev[8:4]), .op_done_in(done),
    .other_running_in(o_run), .other_irq_pending_in(o_pend), .sync_x_in(sync),
    .sync_y_in(o_sync), .op_start_out(start), .op_mode_out(mode), .op_feed_out(feed),
    .op_interp_out(interp), .running_out(run), .sync_out(sync), .sync_mon_out(mon),
    .irq_pending_out(ipend), .irq_n_out(irq_n));

  asev_far_axis u_far (.clock_in(clk), .rst_in(rst), .go_in(go), .pend_in(pend),
    .running_out(o_run), .sync_out(o_sync), .pend_out(o_pend));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulses are counted at the edge, so a one-cycle output is never missed
  always @(posedge clk) begin
    if (start === 1'b1) starts <= starts + 1;
    if (sync === 1'b1 && mon === 1'b1) syncs <= syncs + 1;
  end

  // ==========
  // Tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdat;
    rd_en <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 9'h001 << i;
    @(posedge clk);
    ev <= 9'h000;
  endtask
  task automatic fin;
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task automatic go_far;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Bounded: a start that never comes shows up in the count compare
  task automatic wait_cnt(input int want);
    for (int k = 0; k < 60 && starts < want; k++) @(posedge clk);
  endtask
  task automatic cnd(input logic [3:0] e);
    rd(REG_STATUS, v);
    chk("cnd", 32'(e), 32'(v[3:0]));
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // ==========
  // Tests
  initial begin
    {rst, rd_en, wr_en, done, go, pend} = 6'b100000;
    {addr, wdat, ev} = '0;
    {num_errors, checks_done, starts, syncs} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk("irq_n", 1, irq_n);
    rd(REG_MASK, v);
    chk("mask", 0, v);
    rd(5'h1E, v);
    chk("unmapped", 0, v);
    cnd(CND_STOPPED);
    wr(REG_CAUSE, 32'h0000_1FF0);
    rd(REG_CAUSE, v);
    chk("cause", 0, v);
    wr(REG_MASK, 32'h0000_1FF0);
    for (int i = 0; i < 9; i++) begin
      pulse(i);
      tick(2);
      chk("irq_n", 0, irq_n);
      chk("pend", 1, ipend);
      rd(REG_CAUSE, v);
      chk("cause", 32'h0000_0010 << i, v);
      tick(2);
      chk("irq_n", 1, irq_n);
    end
    wr(REG_MASK, 32'h0000_0120);
    for (int i = 0; i < 9; i++) pulse(i);
    rd(REG_CAUSE, v);
    chk("cause", 32'h0000_0120, v);
    @(posedge clk);
    pend <= 1'b1;
    tick(4);
    chk("irq_n", 0, irq_n);
    chk("pend", 0, ipend);
    @(posedge clk);
    pend <= 1'b0;
    tick(4);
    chk("irq_n", 1, irq_n);
    wr(REG_MASK, 32'h0000_0000);
    wr(REG_ENV5, 32'h0019_0000);
    pulse(1);
    tick(2);
    chk("syncs", 1, syncs);
    pulse(0);
    tick(2);
    chk("syncs", 1, syncs);
    wr(REG_OPMODE, 32'h0008_0000);
    wr(REG_CMD, 32'h0000_0351);
    cnd(CND_WAIT_SYNC);
    chk("starts", 0, starts);
    go_far();
    wait_cnt(1);
    chk("starts", 1, starts);
    chk("run", 1, run);
    fin();
    tick(14);
    chk("run", 0, run);
    // Own sync looped back on the X input, fired by comparator 1
    wr(REG_ENV5, 32'h0001_0000);
    wr(REG_CMD, 32'h0000_0351);
    cnd(CND_WAIT_SYNC);
    pulse(4);
    wait_cnt(2);
    chk("starts", 2, starts);
    chk("syncs", 2, syncs);
    fin();
    tick(2);
    wr(REG_OPMODE, 32'h002C_0000);
    wr(REG_CMD, 32'h0000_0351);
    cnd(CND_WAIT_STOP);
    go_far();
    tick(5);
    chk("starts", 2, starts);
    wait_cnt(3);
    chk("starts", 3, starts);
    chk("mode", 32'h002C_0000, mode);
    fin();
    wr(REG_OPMODE, MODE_CIRC);
    wr(REG_CMD, 32'h0000_0351);
    wait_cnt(4);
    chk("starts", 4, starts);
    chk("interp", 1, interp);
    wr(REG_OPMODE, 32'h001C_0000);
    wr(REG_CMD, 32'h0000_0351);
    fin();
    wait_cnt(5);
    chk("starts", 4, starts);
    cnd(CND_WAIT_STOP);
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    chk("run", 0, run);
    wr(REG_ENV2, 32'h1000_0000);
    wr(REG_OPMODE, MODE_CIRC);
    wr(REG_CMD, 32'h0000_0351);
    wait_cnt(5);
    wr(REG_OPMODE, 32'h001C_0000);
    wr(REG_CMD, 32'h0000_0351);
    fin();
    wait_cnt(6);
    chk("starts", 6, starts);
    // Both axes watched: own finish arms, the far axis stop releases
    wr(REG_OPMODE, 32'h003C_0000);
    wr(REG_CMD, 32'h0000_0351);
    go_far();
    fin();
    tick(3);
    chk("starts", 6, starts);
    cnd(CND_WAIT_STOP);
    wait_cnt(7);
    chk("starts", 7, starts);
    wr(REG_FEED, 32'h0000_1388);
    wr(REG_OPMODE, MODE_LINEAR);
    wr(REG_CMD, 32'h0000_0351);
    fin();
    wait_cnt(8);
    chk("starts", 8, starts);
    chk("mode", MODE_LINEAR, mode);
    chk("interp", 1, interp);
    chk("feed", 32'h0000_1388, feed);
    rd(REG_FEED, v);
    chk("feed_reg", 32'h0000_1388, v);
    fin();
    tick(2);
    chk("run", 0, run);
    give_verdict();
  end
endmodule
`default_nettype wire
